// *** src/scb_pkg.sv ***
/*
 * constants, types and carriers of the configuration reader.
 * assumes one 250 MHz clock and a synchronous active-high reset.
 */
package scb_pkg;

    // ==========================================================
    // array geometry
    // ==========================================================
    localparam int ARRAY_BITS = 4194304;      // one-bit-wide store, 4M locations
    localparam int WORD_W = 32;               // bits held per stored word
    localparam int WORD_DEPTH = ARRAY_BITS / WORD_W;
    localparam int BIT_CNT_W = 5;             // selects a bit within a word
    localparam int WORD_ADDR_W = 17;          // selects a word in the array

    localparam logic [WORD_W-1:0] ERASED_WORD = 32'hFFFFFFFF;   // blank cells read one
    localparam logic [BIT_CNT_W-1:0] BIT_FIRST = 5'h00;
    localparam logic [BIT_CNT_W-1:0] BIT_LAST = 5'h1F;
    localparam logic [WORD_ADDR_W-1:0] WORD_FIRST = 17'h00000;
    localparam logic [WORD_ADDR_W-1:0] WORD_LAST = 17'h1FFFF;

    // ==========================================================
    // polarity of the combined clear / output-gate input
    // ==========================================================
    localparam logic CLEAR_LEVEL_DEFAULT = 1'b0;   // low clears, high gates output on

    // ==========================================================
    // power-on reset timing
    // ==========================================================
    localparam int CLK_PERIOD_PS = 4000;      // 250 MHz
    localparam int POR_TIME_NS = 1000;        // least power-up reset duration
    localparam int POR_CYCLES = (POR_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int POR_CNT_W = 8;
    localparam logic [POR_CNT_W-1:0] POR_CNT_RESET = 8'h00;
    localparam logic [POR_CNT_W-1:0] POR_CNT_LAST = POR_CNT_W'(POR_CYCLES - 1);

    // ==========================================================
    // operating modes
    // ==========================================================
    typedef enum logic [2:0]
    {
        MODE_POWER_UP = 3'b000,
        MODE_STANDBY = 3'b001,
        MODE_READ = 3'b010,
        MODE_PROGRAM = 3'b011,
        MODE_POWER_DOWN = 3'b100
    } scb_mode_e;

    // ==========================================================
    // carriers
    // ==========================================================
    typedef struct packed
    {
        logic en; // word write pulse
        logic [WORD_ADDR_W-1:0] addr; // word index
        logic [WORD_W-1:0] data; // bit 0 leaves first
    } scb_prog_wr_s;

    typedef struct packed
    {
        logic en; // polarity write pulse
        logic clear_high; // 1: high level clears
    } scb_pol_wr_s;

    typedef struct packed
    {
        scb_mode_e mode; // operating mode
        logic end_reached; // whole array read; reads low outside read and standby
        logic clear_level; // clearing level
        logic [WORD_ADDR_W-1:0] word_addr; // address counter
        logic [BIT_CNT_W-1:0] bit_cnt; // bit counter
    } scb_status_s;

endpackage

// *** src/scb_array.sv ***
/*
 * nonvolatile array: 32-bit words, registered read.
 * assumes the caller gates writes.
 */
module scb_array
    import scb_pkg::*;
(
    input wire logic clock,
    input wire logic wr_en,
    input wire logic [scb_pkg::WORD_ADDR_W-1:0] wr_addr,
    input wire logic [scb_pkg::WORD_W-1:0] wr_data,
    input wire logic [scb_pkg::WORD_ADDR_W-1:0] rd_addr,
    output logic [scb_pkg::WORD_W-1:0] rd_data
);

    // ==========================================================
    // storage
    // ==========================================================
    // no reset: contents survive resets
    logic [WORD_W-1:0] mem [0:WORD_DEPTH-1];

    // factory blank state, every cell a one
    initial
    begin
        for (int i = 0; i < WORD_DEPTH; i++)
        begin
            mem[i] = ERASED_WORD;
        end
    end

    // ==========================================================
    // access
    // ==========================================================
    // read first, registered read; a same-address read sees old data
    always_ff @(posedge clock)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end

endmodule

// *** src/scb_por.sv ***
/*
 * power-up sequencer: done after a fixed count.
 * assumes a synchronous active-high reset.
 */
module scb_por
    import scb_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    output logic done
);

    // ==========================================================
    // counter state
    // ==========================================================
    logic [POR_CNT_W-1:0] count;        // cycles spent in power-up
    logic [POR_CNT_W-1:0] next_count;
    logic next_done;

    // count up and stop once the last cycle is reached
    always_comb
    begin
        next_count = count;
        next_done = done;
        if (!done)
        begin
            if (count == POR_CNT_LAST)
            begin
                next_done = 1'b1;       // sequence complete
            end
            else
            begin
                next_count = count + POR_CNT_W'(1);
            end
        end
    end

    // register only
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            count <= POR_CNT_RESET;
            done <= 1'b0;
        end
        else
        begin
            count <= next_count;
            done <= next_done;
        end
    end

endmodule

// *** src/scb_reader.sv ***
/*
 * bitstream reader: streams the one-bit array out, one bit per rising
 * configuration clock edge, with select, clear/gate, chain out, ready,
 * standby, power-down and hand-over of shared pins to programming.
 * assumes synchronous pins; two-wire framing lives outside.
 */

module scb_reader
    import scb_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic cfg_clk,
    input wire logic chip_select_n,
    input wire logic clear_or_gate,
    input wire logic serial_program_select_n,
    input wire logic power_down_in,
    input wire logic data_in,
    output logic data_out,
    output logic data_oe,
    input wire logic bus_id_or_chain_out_in,
    output logic bus_id_or_chain_out_out,
    output logic bus_id_or_chain_out_oe,
    output logic ready_out,
    output logic ready_oe,
    input wire scb_pkg::scb_prog_wr_s prog_wr,
    input wire scb_pkg::scb_pol_wr_s pol_wr,
    input wire logic prog_data_pull_low,
    output logic prog_data_sample,
    output logic bus_id_pin,
    output logic two_wire_program_link,
    output scb_pkg::scb_status_s status
);

    // ==========================================================
    // helpers
    // ==========================================================
    // read-out counters live
    function automatic logic is_readout(input scb_mode_e m);
        is_readout = (m == MODE_READ) || (m == MODE_STANDBY);
    endfunction

    // ==========================================================
    // declarations
    // ==========================================================
    logic por_done; // power-up done
    logic cfg_clk_prev; // last clock pin sample
    logic cfg_clk_rise; // clock pin rise pulse
    scb_mode_e mode; // operating mode
    scb_mode_e next_mode;
    logic clear_level; // clearing level
    logic next_clear_level;
    logic clear_now; // input at clearing level
    logic gate_on; // input at enable level
    logic [WORD_ADDR_W-1:0] word_addr; // address counter
    logic [WORD_ADDR_W-1:0] next_word_addr;
    logic [BIT_CNT_W-1:0] bit_cnt; // bit counter
    logic [BIT_CNT_W-1:0] next_bit_cnt;
    logic end_reached; // last bit sent
    logic next_end_reached;
    logic data_bit; // bit on the data pin
    logic next_data_bit;
    logic [WORD_W-1:0] rd_word; // word at the address
    logic id_sample; // shared pin as select
    logic next_id_sample;
    logic data_sample; // data pin in programming
    logic next_data_sample;
    logic chain_n; // active-low chain enable

    // ==========================================================
    // submodules
    // ==========================================================
    // power-up sequencer drives the ready indicator
    scb_por u_por
    (
        .clock(clock),
        .reset(reset),
        .done(por_done)
    );

    // array of 4M single-bit locations stored as words
    scb_array u_array
    (
        .clock(clock),
        .wr_en(prog_wr.en && (mode == MODE_PROGRAM)),
        .wr_addr(prog_wr.addr),
        .wr_data(prog_wr.data),
        .rd_addr(word_addr),
        .rd_data(rd_word)
    );

    // ==========================================================
    // configuration clock pin edge detect
    // ==========================================================
    // pin is synchronous: one register finds the edge
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            cfg_clk_prev <= 1'b0;
        end
        else
        begin
            cfg_clk_prev <= cfg_clk;
        end
    end

    // the pin is the only thing that steps the counters
    assign cfg_clk_rise = cfg_clk && !cfg_clk_prev;

    // ==========================================================
    // mode selection
    // ==========================================================
    // power-up first, then power-down, then programming, then select
    always_comb
    begin
        if (!por_done)
        begin
            next_mode = MODE_POWER_UP;
        end
        else if (power_down_in)
        begin
            next_mode = MODE_POWER_DOWN;
        end
        else if (!serial_program_select_n)
        begin
            next_mode = MODE_PROGRAM;       // chip select not consulted
        end
        else if (chip_select_n)
        begin
            next_mode = MODE_STANDBY;
        end
        else
        begin
            next_mode = MODE_READ;
        end
    end

    // register only
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            mode <= MODE_POWER_UP;
        end
        else
        begin
            mode <= next_mode;
        end
    end

    // ==========================================================
    // clear/gate polarity
    // ==========================================================
    // volatile: back to default after reset, so rewrite if changed
    always_comb
    begin
        next_clear_level = clear_level;
        if ((mode == MODE_PROGRAM) && pol_wr.en)
        begin
            next_clear_level = pol_wr.clear_high;
        end
    end

    // register only
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            clear_level <= CLEAR_LEVEL_DEFAULT;
        end
        else
        begin
            clear_level <= next_clear_level;
        end
    end

    // the same input both clears and gates, at opposite levels, never both at once
    assign clear_now = (clear_or_gate == clear_level);
    assign gate_on = !clear_now;

    // ==========================================================
    // read-out counters and data bit
    // ==========================================================
    // edges must be at least two clocks apart so rd_word has settled
    always_comb
    begin
        next_word_addr = word_addr;
        next_bit_cnt = bit_cnt;
        next_end_reached = end_reached;
        next_data_bit = data_bit;
        case (mode)
            MODE_READ, MODE_STANDBY:
            begin
                if (clear_now)
                begin
                    // clearing level: back to the first bit
                    next_word_addr = WORD_FIRST;
                    next_bit_cnt = BIT_FIRST;
                    next_end_reached = 1'b0;    // gate off ends the chain hold
                end
                else if ((mode == MODE_READ) && cfg_clk_rise && !end_reached)
                begin
                    // present the bit, then step; standby holds
                    next_data_bit = rd_word[bit_cnt];
                    if (bit_cnt == BIT_LAST)
                    begin
                        if (word_addr == WORD_LAST)
                        begin
                            // counters park at the top until cleared
                            next_end_reached = 1'b1;
                        end
                        else
                        begin
                            next_bit_cnt = BIT_FIRST;
                            next_word_addr = word_addr + WORD_ADDR_W'(1);
                        end
                    end
                    else
                    begin
                        next_bit_cnt = bit_cnt + BIT_CNT_W'(1);
                    end
                end
            end
            default:
            begin
                // power-up, power-down and programming leave them alone
                next_word_addr = word_addr;
            end
        endcase
    end

    // register only
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            word_addr <= WORD_FIRST;
            bit_cnt <= BIT_FIRST;
            end_reached <= 1'b0;
            data_bit <= 1'b1;               // matches a blank cell
        end
        else
        begin
            word_addr <= next_word_addr;
            bit_cnt <= next_bit_cnt;
            end_reached <= next_end_reached;
            data_bit <= next_data_bit;
        end
    end

    // ==========================================================
    // programming-mode pin samples
    // ==========================================================
    // outside programming the select reads low, as the pull-down would
    always_comb
    begin
        next_id_sample = 1'b0;
        next_data_sample = 1'b1;            // idle line rests high
        if (mode == MODE_PROGRAM)
        begin
            next_id_sample = bus_id_or_chain_out_in;
            next_data_sample = data_in;
        end
    end

    // register only
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            id_sample <= 1'b0;
            data_sample <= 1'b1;
        end
        else
        begin
            id_sample <= next_id_sample;
            data_sample <= next_data_sample;
        end
    end

    // ==========================================================
    // pins
    // ==========================================================
    // chain: high until the last bit is sent, then follows select
    assign chain_n = end_reached ? chip_select_n : 1'b1;

    // shared pin: driven output in read-out, released in programming
    assign bus_id_or_chain_out_out = chain_n;
    assign bus_id_or_chain_out_oe = (mode != MODE_PROGRAM);

    // data: three-state, pull-low in programming
    assign data_out = (mode == MODE_PROGRAM) ? 1'b0 : data_bit;
    assign data_oe = (mode == MODE_PROGRAM) ? prog_data_pull_low
                   : ((mode == MODE_READ) && gate_on);  // standby keeps it off

    // ready low through power-up
    assign ready_out = 1'b0;
    assign ready_oe = !por_done;

    // ==========================================================
    // user-side outputs
    // ==========================================================
    assign prog_data_sample = data_sample;
    assign bus_id_pin = id_sample;
    assign two_wire_program_link = (mode == MODE_PROGRAM);

    // status, all from registers
    always_comb
    begin
        status.mode = mode;
        status.end_reached = end_reached && is_readout(mode);
        status.clear_level = clear_level;
        status.word_addr = word_addr;
        status.bit_cnt = bit_cnt;
    end

endmodule

// *** verification/scb_fpga_model.sv ***
/* fpga port model: pulses the configuration clock, shifts bits in.
   assumes reads start after ready release. */
module scb_fpga_model
(
    input wire logic clock,
    input wire logic data_out,
    input wire logic data_oe,
    output logic cfg_clk
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // clock pulses
    // ==========================================================
    // configuration clock rests low between frames
    initial cfg_clk = 1'b0;
    // hold: cycles per phase, 2 fastest
    task automatic read_bits(input int n, input int hold, output logic [31:0] w);
        w = 32'h00000000;
        for (int i = 0; i < n; i++)
        begin
            @(posedge clock);
            cfg_clk <= 1'b1;
            repeat (hold) @(posedge clock);
            cfg_clk <= 1'b0;
            repeat (hold - 1) @(posedge clock);
            // released line: unknown
            w[i] = data_oe ? data_out : 1'bx;
        end
    endtask
endmodule

// *** verification/scb_reader_chk.sv ***
/* port checker for the configuration reader.
   assumes one clock, sync active-high reset. */
module scb_reader_chk
    import scb_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic cfg_clk,
    input wire logic chip_select_n,
    input wire logic clear_or_gate,
    input wire logic serial_program_select_n,
    input wire logic power_down_in,
    input wire logic data_out,
    input wire logic data_oe,
    input wire logic bus_id_or_chain_out_out,
    input wire logic bus_id_or_chain_out_oe,
    input wire logic ready_oe,
    input wire logic prog_data_pull_low,
    input wire logic two_wire_program_link,
    input wire scb_pkg::scb_status_s status
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    // ==========================================================
    // helpers
    // ==========================================================
    logic [8:0] since_rst; // cycles since reset release, saturating
    logic [8:0] next_since_rst;
    logic gated; // gate input away from its clearing level
    assign gated = clear_or_gate != status.clear_level;
    always_comb next_since_rst = reset ? 9'h000 : since_rst + {8'h00, since_rst != 9'h1FF};
    always_ff @(posedge clock) since_rst <= next_since_rst;
    // ==========================================================
    // assertions
    // ==========================================================
    a_ready_held: assert property (since_rst < 9'h0F0 |-> ready_oe)
        else $error("ready released too early");
    a_ready_free: assert property (since_rst > 9'h104 |-> !ready_oe)
        else $error("ready still pulled low");
    a_oe_gated: assert property (data_oe && !two_wire_program_link |-> gated && status.mode == MODE_READ)
        else $error("data driver on while not gated");
    a_standby_freeze: assert property (status.mode == MODE_STANDBY && gated |=> $stable(status.bit_cnt) && $stable(status.word_addr))
        else $error("counters moved in standby");
    a_clear_zero: assert property (status.mode inside {MODE_READ, MODE_STANDBY} && !gated
        |=> status.bit_cnt == BIT_FIRST && status.word_addr == WORD_FIRST && !status.end_reached)
        else $error("clear level left counters");
    a_step_once: assert property (status.mode == MODE_READ && gated && cfg_clk && !$past(cfg_clk)
        && !status.end_reached |=> status.bit_cnt == $past(status.bit_cnt) + 5'h01)
        else $error("bit counter missed a step");
    a_no_idle_step: assert property (!(cfg_clk && !$past(cfg_clk)) && gated && status.mode != MODE_PROGRAM |=> $stable(status.bit_cnt))
        else $error("bit counter moved without clock");
    a_chain_follow: assert property (bus_id_or_chain_out_oe |-> bus_id_or_chain_out_out == (status.end_reached ? chip_select_n : 1'b1))
        else $error("chain output wrong");
    a_prog_pins: assert property (status.mode == MODE_PROGRAM |-> two_wire_program_link && !bus_id_or_chain_out_oe)
        else $error("shared pin driven in programming");
    a_prog_stays: assert property (status.mode == MODE_PROGRAM && !serial_program_select_n && !power_down_in |=> status.mode == MODE_PROGRAM)
        else $error("programming mode left");
    a_pull_low: assert property (two_wire_program_link && prog_data_pull_low |-> data_oe && !data_out)
        else $error("data pin not pulled low");
    a_pd_off: assert property ((power_down_in && serial_program_select_n && !ready_oe)[*3] |-> status.mode == MODE_POWER_DOWN && !data_oe)
        else $error("power-down not entered");
    c_step: cover property (status.mode == MODE_READ && gated && cfg_clk);
    c_standby: cover property (status.mode == MODE_STANDBY);
    c_pull: cover property (two_wire_program_link && prog_data_pull_low);
endmodule
bind scb_reader scb_reader_chk scb_reader_chk_inst (
    .clock(clock), .reset(reset), .cfg_clk(cfg_clk), .chip_select_n(chip_select_n),
    .clear_or_gate(clear_or_gate), .serial_program_select_n(serial_program_select_n),
    .power_down_in(power_down_in), .data_out(data_out), .data_oe(data_oe),
    .bus_id_or_chain_out_out(bus_id_or_chain_out_out), .ready_oe(ready_oe),
    .bus_id_or_chain_out_oe(bus_id_or_chain_out_oe), .prog_data_pull_low(prog_data_pull_low),
    .two_wire_program_link(two_wire_program_link), .status(status)
);

// *** verification/scb_reader_tb.sv ***
/* bench for the configuration reader.
   assumes the checker binds itself. */
module scb_reader_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import scb_pkg::*;
    // ==========================================================
    // stimulus and observed signals
    // ==========================================================
    logic clock, cfg_clk, data_out, data_oe, chain_out, chain_oe, ready_out, ready_oe;
    logic reset = 1'b1;
    logic chip_select_n = 1'b0;
    logic clear_or_gate = 1'b1;
    logic serial_program_select_n = 1'b1; // held high for loading
    logic power_down_in = 1'b0;
    logic data_drive = 1'b1; // pull-up level on the data line
    logic shared_in = 1'b0;
    logic prog_data_pull_low = 1'b0;
    logic data_line, shared_line, prog_data_sample, bus_id_pin, two_wire_program_link;
    scb_prog_wr_s prog_wr = '0;
    scb_pol_wr_s pol_wr = '0;
    scb_status_s status;
    int fails = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [31:0] w;
    localparam logic [31:0] W0 = 32'hA5C30F96;
    localparam logic [31:0] W1 = 32'h12345678;
    // wire levels from every party's enable
    assign data_line = data_oe ? data_out : data_drive;
    assign shared_line = chain_oe ? chain_out : shared_in; // next chip select
    scb_reader scb_reader_inst (
        .clock(clock), .reset(reset), .cfg_clk(cfg_clk), .chip_select_n(chip_select_n),
        .clear_or_gate(clear_or_gate), .serial_program_select_n(serial_program_select_n),
        .power_down_in(power_down_in), .data_in(data_line), .data_out(data_out),
        .data_oe(data_oe), .bus_id_or_chain_out_in(shared_line),
        .bus_id_or_chain_out_out(chain_out), .bus_id_or_chain_out_oe(chain_oe),
        .ready_out(ready_out), .ready_oe(ready_oe), .prog_wr(prog_wr), .pol_wr(pol_wr),
        .prog_data_pull_low(prog_data_pull_low), .prog_data_sample(prog_data_sample),
        .bus_id_pin(bus_id_pin), .two_wire_program_link(two_wire_program_link),
        .status(status)
    );
    scb_fpga_model scb_fpga_model_inst (
        .clock(clock), .data_out(data_out), .data_oe(data_oe), .cfg_clk(cfg_clk)
    );
    // ==========================================================
    // clock, timeout and shared tasks
    // ==========================================================
    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // the whole run needs about 1330 cycles
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fails++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        if (fails == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic chk_bit(input string name, input logic exp, input logic got);
        chk_word(name, {31'h0, exp}, {31'h0, got});
    endtask
    task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic read(input int n, input int hold);
        scb_fpga_model_inst.read_bits(n, hold, w);
        tick(1);
    endtask
    // ==========================================================
    // scenarios
    // ==========================================================
    task automatic t_power_up();
        tick(200);
        chk_bit("ready_oe", 1'b1, ready_oe);
        chk_bit("ready_out", 1'b0, ready_out);
        tick(60); // no read-out before the release
        chk_bit("ready_oe", 1'b0, ready_oe);
        chk_word("mode", 32'(MODE_READ), 32'(status.mode));
        chk_bit("chain_out", 1'b1, chain_out);
        read(32, 2);
        chk_word("blank_word", 32'hFFFFFFFF, w);
        chk_word("word_addr", 32'h00000001, 32'(status.word_addr));
        chk_bit("data_oe", 1'b1, data_oe);
    endtask
    task automatic t_program();
        serial_program_select_n = 1'b0;
        chip_select_n = 1'b1;
        shared_in = 1'b1;
        tick(3);
        chk_bit("link", 1'b1, two_wire_program_link);
        chk_bit("chain_oe", 1'b0, chain_oe);
        chk_word("mode", 32'(MODE_PROGRAM), 32'(status.mode));
        chk_bit("bus_id_pin", 1'b1, bus_id_pin);
        prog_data_pull_low = 1'b1;
        tick(1);
        chk_bit("data_out", 1'b0, data_out);
        chk_bit("sample", 1'b0, prog_data_sample);
        prog_data_pull_low = 1'b0;
        prog_wr = '{1'b1, 17'h00000, W0};
        tick(1);
        chk_bit("data_oe", 1'b0, data_oe);
        prog_wr = '{1'b1, 17'h00001, W1};
        tick(1);
        prog_wr.en = 1'b0;
        serial_program_select_n = 1'b1;
        chip_select_n = 1'b0;
        clear_or_gate = 1'b0;
        tick(3);
        chk_word("counters", 32'h0, {10'h000, status.word_addr, status.bit_cnt});
        chk_bit("data_oe", 1'b0, data_oe);
        clear_or_gate = 1'b1;
        tick(2);
        read(32, 5);
        chk_word("word0", W0, w);
        read(32, 2);
        chk_word("word1", W1, w);
    endtask
    task automatic t_standby();
        clear_or_gate = 1'b0;
        tick(2);
        clear_or_gate = 1'b1;
        tick(2);
        read(4, 2);
        chip_select_n = 1'b1;
        tick(2);
        chk_word("mode", 32'(MODE_STANDBY), 32'(status.mode));
        chk_bit("data_oe", 1'b0, data_oe);
        read(3, 2);
        chk_word("bit_cnt", 32'h00000004, 32'(status.bit_cnt));
        chip_select_n = 1'b0;
        tick(2);
        read(28, 2);
        chk_word("resumed", W0 >> 4, w);
    endtask
    task automatic t_polarity();
        serial_program_select_n = 1'b0;
        tick(3);
        pol_wr = '{1'b1, 1'b1};
        tick(1);
        pol_wr.en = 1'b0;
        tick(1);
        chk_bit("clear_level", 1'b1, status.clear_level);
        serial_program_select_n = 1'b1;
        tick(3);
        chk_bit("data_oe", 1'b0, data_oe);
        chk_word("counters", 32'h0, {10'h000, status.word_addr, status.bit_cnt});
        clear_or_gate = 1'b0;
        tick(2);
        read(8, 2);
        chk_word("low_gate", {24'h000000, W0[7:0]}, w);
    endtask
    task automatic t_reset_power_down();
        reset = 1'b1;
        tick(2);
        reset = 1'b0;
        tick(1);
        chk_bit("clear_level", 1'b0, status.clear_level);
        chk_bit("ready_oe", 1'b1, ready_oe);
        clear_or_gate = 1'b1;
        tick(260);
        power_down_in = 1'b1;
        tick(3);
        chk_word("mode", 32'(MODE_POWER_DOWN), 32'(status.mode));
        chk_bit("data_oe", 1'b0, data_oe);
        power_down_in = 1'b0;
        tick(3);
        chk_bit("data_oe", 1'b1, data_oe);
    endtask
    // ==========================================================
    // main sequence
    // ==========================================================
    initial
    begin
        tick(12);
        reset = 1'b0;
        t_power_up();
        t_program();
        t_standby();
        t_polarity();
        t_reset_power_down();
        report_and_stop();
    end
endmodule
